// File: shared/sol_pkg.sv
// Shared constants and types for the drive status-output logic.
`default_nettype none

package sol_pkg;

    // Clock and watchdog time base.
    localparam int CLK_PERIOD_NS = 10;
    localparam int WD_TICK_NS = 10_000_000;
    localparam int WD_TICK_CYCLES = WD_TICK_NS / CLK_PERIOD_NS;

    // Percent values are in tenths of a percent of full scale.
    localparam int PCT_W = 10;
    localparam logic [PCT_W-1:0] PCT_FULL = 10'h3e8;

    // Watchdog timeouts are counted in 10 ms ticks; zero disables the dog.
    localparam int WD_W = 16;

    // Logic combiner source selection.
    localparam int SEL_W = 4;
    localparam int NUM_SRC = 9;
    localparam int AUX_W = 5;
    localparam logic [SEL_W-1:0] SRC_BOOST = 4'h0;
    localparam logic [SEL_W-1:0] SRC_SERIAL_DC = 4'h1;
    localparam logic [SEL_W-1:0] SRC_OPTION_DC = 4'h2;
    localparam logic [SEL_W-1:0] SRC_LOW_LOAD = 4'h3;
    localparam logic [SEL_W-1:0] SRC_AUX0 = 4'h4;

    // Logic combiner operators.
    localparam logic [1:0] OP_AND = 2'h0;
    localparam logic [1:0] OP_OR = 2'h1;
    localparam logic [1:0] OP_XOR = 2'h2;

    // Reaction to a serial network timeout.
    localparam logic [2:0] RSP_TRIP = 3'h0;
    localparam logic [2:0] RSP_DECEL_TRIP = 3'h1;
    localparam logic [2:0] RSP_IGNORE = 3'h2;
    localparam logic [2:0] RSP_COAST = 3'h3;
    localparam logic [2:0] RSP_DECEL = 3'h4;
    localparam logic [7:0] ERR_CODE_COMM = 8'h3c;
    localparam logic [7:0] ERR_CODE_NONE = 8'h00;

    // Low-load detection modes.
    localparam logic [1:0] LL_OFF = 2'h0;
    localparam logic [1:0] LL_ALL = 2'h1;
    localparam logic [1:0] LL_CONST = 2'h2;

    // Run state of the drive.
    typedef enum logic {
        SOL_STOP = 1'b0,
        SOL_RUN = 1'b1
    } sol_run_t;

endpackage

`default_nettype wire

// File: core/sol_watchdog.sv
// Communication watchdog that flags a link as lost after a silent timeout.
`default_nettype none

module sol_watchdog import sol_pkg::*; (
    input wire logic sys_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic ce, // Clock enable; state freezes while low.
    input wire logic tick, // One-cycle 10 ms time base pulse.
    input wire logic msg_valid, // One-cycle pulse per valid message.
    input wire logic [WD_W-1:0] timeout, // Timeout in ticks, zero disables.
    output logic expired_ff // High while the link is considered lost.
);

    logic [WD_W-1:0] elapsed_ff;
    logic [WD_W-1:0] nxt_elapsed;
    logic nxt_expired;
    logic disabled;
    logic restart;

    // Restart on traffic, count ticks up to the timeout and then hold.
    assign disabled = (timeout == {WD_W{1'b0}});
    assign restart = disabled | msg_valid; // R16
    assign nxt_elapsed = restart ? {WD_W{1'b0}} :
        ((tick && elapsed_ff < timeout) ? elapsed_ff + 1'b1 : elapsed_ff);
    assign nxt_expired = !restart && (elapsed_ff >= timeout); // R7 R8 R10

    // Counter and flag registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            elapsed_ff <= {WD_W{1'b0}};
            expired_ff <= 1'b0;
        end else if (ce) begin
            elapsed_ff <= nxt_elapsed;
            expired_ff <= nxt_expired;
        end
    end

    a_wd_disabled_quiet: assert property (@(posedge sys_clk) disable iff (rst) // R16
        (ce && disabled) |=> !expired_ff)
        else $error("watchdog flagged while disabled");

    a_wd_traffic_clears: assert property (@(posedge sys_clk) disable iff (rst) // R8
        (ce && msg_valid) |=> (!expired_ff && elapsed_ff == {WD_W{1'b0}}))
        else $error("message did not restart watchdog");

    a_wd_silence_trips: assert property (@(posedge sys_clk) disable iff (rst) // R7
        (ce && !restart && elapsed_ff >= timeout) |=> expired_ff)
        else $error("watchdog missed its timeout");

endmodule

`default_nettype wire

// File: core/sol_status_out.sv
// Status-output logic: second-stage boost, link watchdogs, combiner, low load.
`default_nettype none

// Operation
// R1: Running and PV below lower limit: boost on.
// R2: PV above upper limit: boost off.
// R3: PV between limits: boost holds previous state.
// R4: Run command removed: stop, boost forced off.
// R5: Setpoint and limits compared in percent.
// R6: Second stage runs while boost is asserted.
// R7: Serial silence past timeout: disconnect asserted.
// R8: Regular serial traffic keeps disconnect off.
// R9: Serial timeout acts per error-response selection.
// R10: Option fieldbus watchdog with own timeout.
// R11: Combiner inputs picked from other status outputs.
// R12: Combiner applies AND, OR or XOR.
// R13: Combiner output follows Boolean result.
// R14: Current below threshold: low-load on.
// R15: Current above threshold: low-load off.
// R16: Valid message restarts watchdog; zero disables.
// R17: Current equal to threshold: low-load holds.
module sol_status_out import sol_pkg::*; #(
    parameter int TICK_CYCLES = WD_TICK_CYCLES // Cycles per 10 ms tick.
) (
    input wire logic sys_clk, // System clock, 100 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic ce, // Clock enable; all state freezes while low.
    input wire logic forward_run_cmd, // Forward run terminal, asynchronous.
    input wire logic fault_reset, // Trip reset terminal, asynchronous.
    input wire logic [PCT_W-1:0] process_variable, // PV, 0.1 percent units.
    input wire logic [PCT_W-1:0] setpoint_value, // Setpoint, 0.1 percent units.
    input wire logic [PCT_W-1:0] pv_limit_a, // PV lower limit, 0.1 percent.
    input wire logic [PCT_W-1:0] pv_limit_b, // PV upper limit, 0.1 percent.
    input wire logic serial_msg_valid, // Pulse per valid serial message.
    input wire logic [WD_W-1:0] serial_watchdog_timeout, // 10 ms ticks.
    input wire logic [2:0] comm_error_response_sel, // Serial timeout reaction.
    input wire logic option_msg_valid, // Pulse per valid fieldbus message.
    input wire logic [WD_W-1:0] option_watchdog_timeout, // 10 ms ticks.
    input wire logic [AUX_W-1:0] aux_status, // Other status outputs.
    input wire logic [SEL_W-1:0] logic_input_a_sel, // Combiner input A.
    input wire logic [SEL_W-1:0] logic_input_b_sel, // Combiner input B.
    input wire logic [1:0] logic_operator_sel, // Combiner operator.
    input wire logic [PCT_W-1:0] output_current, // Current, 0.1 percent.
    input wire logic [PCT_W-1:0] low_load_threshold, // Low-load level.
    input wire logic [1:0] low_load_mode_sel, // Low-load mode.
    input wire logic at_constant_speed, // Drive is at constant speed.
    output logic running_ff, // Drive is in run state.
    output logic second_stage_boost_out_ff, // Run command to stage two.
    output logic pv_below_setpoint_ff, // PV is under the setpoint.
    output logic serial_net_disconnect_out_ff, // Serial link lost.
    output logic option_net_disconnect_out_ff, // Fieldbus link lost.
    output logic comm_trip_ff, // Drive tripped on a serial timeout.
    output logic [7:0] trip_error_code_ff, // Alarm code of the trip.
    output logic comm_decel_ff, // Request to decelerate to stop.
    output logic comm_coast_ff, // Request to let the motor coast.
    output logic logic_out_ff, // Combined logic output.
    output logic low_load_out_ff // Output current is low.
);

    // Picks one of the nine status sources; an unused code reads as zero.
    function automatic logic sol_pick(input logic [SEL_W-1:0] sel,
                                      input logic [NUM_SRC-1:0] src);
        logic bit_val;
        bit_val = 1'b0;
        if (sel < SEL_W'(NUM_SRC)) begin
            bit_val = src[sel];
        end
        return bit_val;
    endfunction

    logic run_meta_ff;
    logic run_sync_ff;
    logic rstc_meta_ff;
    logic rstc_sync_ff;
    sol_run_t run_state_ff;
    sol_run_t nxt_run_state;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic serial_dc_prev_ff;
    logic nxt_boost;
    logic pv_low;
    logic pv_high;
    logic cur_low;
    logic cur_high;
    logic ll_enabled;
    logic nxt_low_load;
    logic [NUM_SRC-1:0] logic_src;
    logic pick_a;
    logic pick_b;
    logic nxt_logic;
    logic serial_timeout_evt;
    logic rsp_trip;
    logic rsp_decel;
    logic rsp_coast;
    logic nxt_trip;
    logic nxt_decel;
    logic nxt_coast;

    // Terminals come from outside the clock domain and pass two flip-flops.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_meta_ff <= 1'b0;
            run_sync_ff <= 1'b0;
            rstc_meta_ff <= 1'b0;
            rstc_sync_ff <= 1'b0;
        end else if (ce) begin
            run_meta_ff <= forward_run_cmd;
            run_sync_ff <= run_meta_ff;
            rstc_meta_ff <= fault_reset;
            rstc_sync_ff <= rstc_meta_ff;
        end
    end

    // Run state follows the forward command; removal enters the stop state.
    assign nxt_run_state = run_sync_ff ? SOL_RUN : SOL_STOP; // R4

    // Hysteresis comparisons in tenths of a percent of full scale.
    assign pv_low = process_variable < pv_limit_a; // R5
    assign pv_high = process_variable > pv_limit_b; // R5
    assign nxt_boost = (run_state_ff == SOL_STOP) ? 1'b0 : // R4
        (pv_low ? 1'b1 : // R1
        (pv_high ? 1'b0 : // R2
        second_stage_boost_out_ff)); // R3

    // Boost, run and setpoint status registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_state_ff <= SOL_STOP;
            running_ff <= 1'b0;
            second_stage_boost_out_ff <= 1'b0;
            pv_below_setpoint_ff <= 1'b0;
        end else if (ce) begin
            run_state_ff <= nxt_run_state;
            running_ff <= (nxt_run_state == SOL_RUN);
            second_stage_boost_out_ff <= nxt_boost; // R6
            pv_below_setpoint_ff <= process_variable < setpoint_value; // R5
        end
    end

    // Shared 10 ms time base for both watchdogs.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else if (ce) begin
            tick_ff <= (tick_cnt_ff == 32'(TICK_CYCLES - 1));
            tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_ff + 32'h1;
        end
    end

    // Serial network watchdog.
    sol_watchdog u_serial_wd (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick_ff),
        .msg_valid(serial_msg_valid),
        .timeout(serial_watchdog_timeout),
        .expired_ff(serial_net_disconnect_out_ff)
    );

    // Fieldbus option watchdog with its own timeout.
    sol_watchdog u_option_wd (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick_ff),
        .msg_valid(option_msg_valid),
        .timeout(option_watchdog_timeout),
        .expired_ff(option_net_disconnect_out_ff)
    );

    // Timeout reaction; the timeout event wins over a reset in the same cycle.
    assign serial_timeout_evt = serial_net_disconnect_out_ff && !serial_dc_prev_ff;
    assign rsp_trip = (comm_error_response_sel == RSP_TRIP) ||
        (comm_error_response_sel == RSP_DECEL_TRIP);
    assign rsp_decel = (comm_error_response_sel == RSP_DECEL_TRIP) ||
        (comm_error_response_sel == RSP_DECEL);
    assign rsp_coast = (comm_error_response_sel == RSP_TRIP) ||
        (comm_error_response_sel == RSP_COAST);
    assign nxt_trip = (serial_timeout_evt && rsp_trip) || (comm_trip_ff && !rstc_sync_ff); // R9
    assign nxt_decel = (serial_timeout_evt && rsp_decel) || (comm_decel_ff && running_ff); // R9
    assign nxt_coast = (serial_timeout_evt && rsp_coast) || (comm_coast_ff && running_ff); // R9

    // Serial timeout reaction registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_dc_prev_ff <= 1'b0;
            comm_trip_ff <= 1'b0;
            trip_error_code_ff <= ERR_CODE_NONE;
            comm_decel_ff <= 1'b0;
            comm_coast_ff <= 1'b0;
        end else if (ce) begin
            serial_dc_prev_ff <= serial_net_disconnect_out_ff;
            comm_trip_ff <= nxt_trip;
            trip_error_code_ff <= nxt_trip ? ERR_CODE_COMM : ERR_CODE_NONE;
            comm_decel_ff <= nxt_decel;
            comm_coast_ff <= nxt_coast;
        end
    end

    // Logic combiner over the other status outputs.
    assign logic_src = {aux_status, low_load_out_ff, option_net_disconnect_out_ff,
        serial_net_disconnect_out_ff, second_stage_boost_out_ff};
    assign pick_a = sol_pick(logic_input_a_sel, logic_src); // R11
    assign pick_b = sol_pick(logic_input_b_sel, logic_src); // R11
    assign nxt_logic = (logic_operator_sel == OP_AND) ? (pick_a & pick_b) : // R12
        ((logic_operator_sel == OP_OR) ? (pick_a | pick_b) :
        ((logic_operator_sel == OP_XOR) ? (pick_a ^ pick_b) : 1'b0));

    // Low-load comparison; equality keeps the previous state.
    assign cur_low = output_current < low_load_threshold; // R14
    assign cur_high = output_current > low_load_threshold; // R15
    assign ll_enabled = (low_load_mode_sel == LL_ALL && running_ff) ||
        (low_load_mode_sel == LL_CONST && running_ff && at_constant_speed);
    assign nxt_low_load = !ll_enabled ? 1'b0 :
        (cur_low ? 1'b1 : (cur_high ? 1'b0 : low_load_out_ff)); // R17

    // Combiner and low-load registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            logic_out_ff <= 1'b0;
            low_load_out_ff <= 1'b0;
        end else if (ce) begin
            logic_out_ff <= nxt_logic; // R13
            low_load_out_ff <= nxt_low_load;
        end
    end

    a_boost_stop_off: assert property (@(posedge sys_clk) disable iff (rst) // R4
        (ce && !run_sync_ff) ##1 ce |=> !second_stage_boost_out_ff)
        else $error("boost stayed on after run removal");

    a_boost_low_on: assert property (@(posedge sys_clk) disable iff (rst) // R1
        (ce && run_state_ff == SOL_RUN && pv_low) |=> second_stage_boost_out_ff)
        else $error("boost not set under lower limit");

    a_boost_high_off: assert property (@(posedge sys_clk) disable iff (rst) // R2
        (ce && !pv_low && pv_high) |=> !second_stage_boost_out_ff)
        else $error("boost not cleared over upper limit");

    a_boost_band_hold: assert property (@(posedge sys_clk) disable iff (rst) // R3
        (ce && run_state_ff == SOL_RUN && !pv_low && !pv_high)
        |=> $stable(second_stage_boost_out_ff))
        else $error("boost changed inside the band");

    a_trip_code: assert property (@(posedge sys_clk) disable iff (rst) // R9
        (ce && serial_timeout_evt && rsp_trip)
        |=> (comm_trip_ff && trip_error_code_ff == ERR_CODE_COMM))
        else $error("serial timeout did not trip");

    a_logic_result: assert property (@(posedge sys_clk) disable iff (rst) // R12
        (ce && logic_operator_sel == OP_OR) |=> (logic_out_ff == $past(pick_a | pick_b)))
        else $error("combiner or wrong");

    a_logic_xor: assert property (@(posedge sys_clk) disable iff (rst) // R12
        (ce && logic_operator_sel == OP_XOR) |=> (logic_out_ff == $past(pick_a ^ pick_b)))
        else $error("combiner exclusive or wrong");

    a_low_load_set: assert property (@(posedge sys_clk) disable iff (rst) // R14
        (ce && ll_enabled && cur_low) |=> low_load_out_ff)
        else $error("low load not flagged");

    a_low_load_clear: assert property (@(posedge sys_clk) disable iff (rst) // R15
        (ce && cur_high) |=> !low_load_out_ff)
        else $error("low load not cleared");

    a_low_load_hold: assert property (@(posedge sys_clk) disable iff (rst) // R17
        (ce && ll_enabled && !cur_low && !cur_high) |=> $stable(low_load_out_ff))
        else $error("low load changed at equality");

endmodule

`default_nettype wire

// File: dv/sol_stage_two.sv
// Behavioural model of the second-stage drive that follows the boost output.
`default_nettype none

module sol_stage_two (
    input wire logic sys_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic run_cmd, // Forward run command from the boost output.
    output logic fan_running_ff // High while the second-stage fan runs.
);
    timeunit 1ns;
    timeprecision 1ps;

    // The second stage runs while commanded and stops as soon as released.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fan_running_ff <= 1'b0;
        end else begin
            fan_running_ff <= run_cmd;
        end
    end
endmodule

`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the drive status-output logic.
`default_nettype none

module testbench import sol_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, fwd = 1'b0, fault_reset = 1'b0;
    logic [PCT_W-1:0] pv = '0, sp = 10'h1f4, lim_a = 10'h12c, lim_b = 10'h258;
    logic [PCT_W-1:0] cur = 10'h3e8, thr = 10'h1f4;
    logic ser_msg = 1'b0, opt_msg = 1'b0, at_speed = 1'b0;
    logic [WD_W-1:0] ser_to = '0, opt_to = '0;
    logic [2:0] rsp = RSP_IGNORE;
    logic [AUX_W-1:0] aux = '0;
    logic [SEL_W-1:0] sel_a = SRC_AUX0, sel_b = SRC_AUX0;
    logic [1:0] op = OP_AND, ll_mode = LL_OFF;
    logic running, boost, pv_low, ser_dc, opt_dc, trip, decel, coast, lout, lload, fan;
    logic [7:0] code;
    int miscompares = 0, total_checks = 0, cyc = 0;

    // Clock runs at 100 MHz.
    always #5 sys_clk = ~sys_clk;

    sol_status_out #(.TICK_CYCLES(4)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .forward_run_cmd(fwd),
        .fault_reset(fault_reset), .process_variable(pv), .setpoint_value(sp),
        .pv_limit_a(lim_a), .pv_limit_b(lim_b), .serial_msg_valid(ser_msg),
        .serial_watchdog_timeout(ser_to), .comm_error_response_sel(rsp),
        .option_msg_valid(opt_msg), .option_watchdog_timeout(opt_to),
        .aux_status(aux), .logic_input_a_sel(sel_a), .logic_input_b_sel(sel_b),
        .logic_operator_sel(op), .output_current(cur), .low_load_threshold(thr),
        .low_load_mode_sel(ll_mode), .at_constant_speed(at_speed),
        .running_ff(running), .second_stage_boost_out_ff(boost),
        .pv_below_setpoint_ff(pv_low), .serial_net_disconnect_out_ff(ser_dc),
        .option_net_disconnect_out_ff(opt_dc), .comm_trip_ff(trip),
        .trip_error_code_ff(code), .comm_decel_ff(decel), .comm_coast_ff(coast),
        .logic_out_ff(lout), .low_load_out_ff(lload));

    sol_stage_two stage_u (.sys_clk(sys_clk), .rst(rst), .run_cmd(boost),
        .fan_running_ff(fan));

    // A hang is cut short well after all tests should have ended.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            miscompares++;
            test_done();
        end
    end

    // Waits n rising edges, then steps just past the edge to drive inputs.
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Compares one observed value with its expectation.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Hysteresis of the boost output and its forced release on stop.
    task automatic test_boost();
        fwd = 1'b1;
        pv = 10'h0c8;
        step(8);
        chk(boost, 1'b1, "boost below lower limit");
        chk(fan, 1'b1, "stage two running");
        chk(pv_low, 1'b1, "pv under setpoint");
        pv = 10'h1c2;
        step(4);
        chk(boost, 1'b1, "boost held in band");
        pv = 10'h2bc;
        step(4);
        chk(boost, 1'b0, "boost above upper limit");
        chk(pv_low, 1'b0, "pv over setpoint");
        pv = 10'h258;
        step(4);
        chk(boost, 1'b0, "boost held at upper limit");
        pv = 10'h12c;
        step(4);
        chk(boost, 1'b0, "boost held at lower limit");
        pv = 10'h12b;
        step(4);
        chk(boost, 1'b1, "boost just under lower limit");
        fwd = 1'b0;
        step(8);
        chk(running, 1'b0, "stopped");
        chk(boost, 1'b0, "boost forced off on stop");
        chk(fan, 1'b0, "stage two stopped");
        $display("test_boost done");
    endtask

    // Serial watchdog timing, zero disable and every timeout reaction.
    task automatic test_serial();
        logic [2:0] exp[5];
        exp = '{3'b101, 3'b110, 3'b000, 3'b001, 3'b010};
        fwd = 1'b1;
        ser_to = 16'h0000;
        step(40);
        chk(ser_dc, 1'b0, "disabled dog stays quiet");
        ser_to = 16'h0003;
        for (int i = 0; i < 6; i++) begin
            ser_msg = 1'b1;
            step(1);
            ser_msg = 1'b0;
            step(8);
            chk(ser_dc, 1'b0, "regular traffic keeps link up");
        end
        for (int r = 0; r < 5; r++) begin
            rsp = 3'(r);
            ser_msg = 1'b1;
            step(1);
            ser_msg = 1'b0;
            step(8);
            chk(ser_dc, 1'b0, "no timeout before three ticks");
            step(12);
            chk(ser_dc, 1'b1, "silence asserts disconnect");
            step(2);
            chk({trip, decel, coast}, exp[r], "timeout reaction");
            chk(code, exp[r][2] ? ERR_CODE_COMM : ERR_CODE_NONE, "error code");
            fwd = 1'b0;
            fault_reset = 1'b1;
            ser_msg = 1'b1;
            step(1);
            ser_msg = 1'b0;
            step(7);
            chk(ser_dc, 1'b0, "message clears disconnect");
            chk({trip, decel, coast}, 3'b000, "reaction cleared");
            fault_reset = 1'b0;
            fwd = 1'b1;
        end
        ser_to = 16'h0000;
        $display("test_serial done");
    endtask

    // Option fieldbus watchdog with its own timeout.
    task automatic test_option();
        opt_to = 16'h0002;
        opt_msg = 1'b1;
        step(1);
        opt_msg = 1'b0;
        step(5);
        chk(opt_dc, 1'b0, "option link still up");
        step(10);
        chk(opt_dc, 1'b1, "option silence asserts disconnect");
        chk(ser_dc, 1'b0, "serial dog disabled meanwhile");
        opt_msg = 1'b1;
        step(1);
        opt_msg = 1'b0;
        step(2);
        chk(opt_dc, 1'b0, "option message clears disconnect");
        $display("test_option done");
    endtask

    // Every operator on all four values of one input pair, aux bits 1 and 4.
    task automatic test_logic();
        logic a, b, e;
        sel_a = SRC_AUX0 + 4'h1;
        sel_b = SRC_AUX0 + 4'h4;
        for (int o = 0; o < 3; o++) begin
            for (int v = 0; v < 4; v++) begin
                a = v[0];
                b = v[1];
                op = 2'(o);
                aux = {b, 2'b00, a, 1'b0};
                e = (o == 0) ? (a & b) : (o == 1) ? (a | b) : (a ^ b);
                step(3);
                chk(lout, e, "combined output");
            end
        end
        sel_a = SRC_OPTION_DC;
        sel_b = SRC_OPTION_DC;
        op = OP_AND;
        step(3);
        chk(lout, 1'b1, "combiner on silent option link");
        $display("test_logic done");
    endtask

    // Low-load threshold with hold on equality.
    task automatic test_low_load();
        fwd = 1'b1;
        ll_mode = LL_ALL;
        step(6);
        chk(lload, 1'b0, "high current no low load");
        cur = 10'h190;
        step(3);
        chk(lload, 1'b1, "low current");
        cur = 10'h1f4;
        step(3);
        chk(lload, 1'b1, "equal holds on");
        cur = 10'h1f5;
        step(3);
        chk(lload, 1'b0, "above threshold");
        cur = 10'h1f4;
        step(3);
        chk(lload, 1'b0, "equal holds off");
        ll_mode = LL_CONST;
        cur = 10'h190;
        at_speed = 1'b0;
        step(3);
        chk(lload, 1'b0, "constant mode off speed");
        at_speed = 1'b1;
        step(3);
        chk(lload, 1'b1, "constant mode at speed");
        ll_mode = LL_OFF;
        step(3);
        chk(lload, 1'b0, "mode off clears low load");
        $display("test_low_load done");
    endtask

    // Clock enable low freezes the boost output in place.
    task automatic test_enable();
        pv = 10'h0c8;
        step(3);
        chk(boost, 1'b1, "boost on before freeze");
        ce = 1'b0;
        pv = 10'h2bc;
        step(4);
        chk(boost, 1'b1, "boost frozen while disabled");
        ce = 1'b1;
        step(2);
        chk(boost, 1'b0, "boost released after enable");
        $display("test_enable done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        step(16);
        rst = 1'b0;
        step(2);
        test_boost();
        test_serial();
        test_option();
        test_logic();
        test_low_load();
        test_enable();
        test_done();
    end
endmodule

`default_nettype wire
